// ---- rtl/rss_pkg.sv ----
// package: register map, field layout and types of the ramp start synchronizer
package rss_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_CONFIG = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_PULSE_EXT   = 7'h11;
  localparam logic [ADDR_W-1:0] ADDR_LAUNCH_DLY  = 7'h13;
  localparam logic [ADDR_W-1:0] ADDR_TARGET_POS  = 7'h20;
  localparam logic [ADDR_W-1:0] ADDR_MAX_VEL     = 7'h21;
  localparam logic [ADDR_W-1:0] ADDR_RAMP_MODE   = 7'h22;
  localparam logic [ADDR_W-1:0] ADDR_GEAR        = 7'h23;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_STATUS = 7'h24;

  // ****************************************
  // sync_unit_config fields
  // ****************************************
  localparam int unsigned NUM_DEFER    = 4;
  localparam int unsigned START_EN_LSB = 0;
  localparam int unsigned START_EN_W   = 5;
  localparam int unsigned SHADOW_BIT   = 4;
  localparam int unsigned TRIG_LSB     = 5;
  localparam int unsigned TRIG_W       = 4;
  localparam int unsigned POL_BIT      = 9;
  localparam int unsigned BYPASS_BIT   = 10;
  localparam int unsigned CFG_USED_W   = 11;

  // ****************************************
  // reset values and constants
  // ****************************************
  localparam logic [DATA_W-1:0] RST_ZERO = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CNT_ONE  = 32'h0000_0001;

  typedef enum logic [0:0] {
    TMR_IDLE  = 1'b0,
    TMR_COUNT = 1'b1
  } rss_tmr_t;

endpackage

// ---- rtl/rss_ramp_start_sync.sv ----
// ramp start synchronizer: trigger detection, launch delay, start pin and deferred writes
`timescale 1ns/1ps
module rss_ramp_start_sync import rss_pkg::*; (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // register write port from the serial host
  input  wire logic              regWrEn,
  input  wire logic [ADDR_W-1:0] regWrAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  // register read port
  input  wire logic              regRdEn,
  input  wire logic [ADDR_W-1:0] regRdAddr,
  output logic      [DATA_W-1:0] regRdData,
  output logic                   regRdValid,
  // internal trigger events, levels
  input  wire logic              targetHitEvent,
  input  wire logic              velocityHitEvent,
  input  wire logic              positionCompareEvent,
  // start pin, split
  input  wire logic              startPinIn,
  output logic                   startPinOut,
  output logic                   startPinOe,
  // active ramp parameters and start outputs
  output logic      [DATA_W-1:0] targetPosition,
  output logic      [DATA_W-1:0] maxVelocity,
  output logic      [DATA_W-1:0] rampProfileMode,
  output logic      [DATA_W-1:0] gearFactor,
  output logic                   startPulse,
  output logic                   shadowLoad
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [DATA_W-1:0]                   cfg;
    logic [DATA_W-1:0]                   pulseExt;
    logic [DATA_W-1:0]                   launchDly;
    logic [NUM_DEFER-1:0][DATA_W-1:0]    active;
    logic [NUM_DEFER-1:0][DATA_W-1:0]    pending;
    logic [NUM_DEFER-1:0]                pendFlag;
    rss_tmr_t                            tmr;
    logic [DATA_W-1:0]                   cnt;
    logic                                pinPrev;
    logic [TRIG_W-2:0]                   evtPrev;
    logic                                pinOn;
    logic [DATA_W-1:0]                   outCnt;
    logic                                pinLevel;
    logic                                launch;
    logic                                shadow;
    logic [DATA_W-1:0]                   rdData;
    logic                                rdValid;
  } rss_state_t;

  rss_state_t state_q;
  rss_state_t state_d;

  // ****************************************
  // decoded configuration
  // ****************************************
  logic [START_EN_W-1:0] startEn;
  logic [TRIG_W-1:0]     trigSel;
  logic                  polHigh;
  logic                  bypass;
  logic                  pinIsInput;
  logic                  pinIsOutput;
  logic                  pinActive;
  logic                  extTrig;
  logic                  intTrig;
  logic                  anyTrig;
  logic [TRIG_W-2:0]     evtNow;
  logic [ADDR_W-1:0]     deferAddr [NUM_DEFER];

  assign startEn     = state_q.cfg[START_EN_LSB +: START_EN_W];
  assign trigSel     = state_q.cfg[TRIG_LSB +: TRIG_W];
  assign polHigh     = state_q.cfg[POL_BIT];
  assign bypass      = state_q.cfg[BYPASS_BIT];
  assign pinIsInput  = trigSel[0];
  assign pinIsOutput = !trigSel[0] && (trigSel != '0);
  assign evtNow      = {positionCompareEvent, velocityHitEvent, targetHitEvent};
  assign deferAddr[0] = ADDR_TARGET_POS;
  assign deferAddr[1] = ADDR_MAX_VEL;
  assign deferAddr[2] = ADDR_RAMP_MODE;
  assign deferAddr[3] = ADDR_GEAR;

  // pin level mapped to active sense by one polarity bit
  assign pinActive = polHigh ? startPinIn : !startPinIn;
  // edges into the active state, never levels
  assign extTrig = pinIsInput && pinActive && !state_q.pinPrev;
  assign intTrig = |(trigSel[TRIG_W-1:1] & evtNow & ~state_q.evtPrev);
  assign anyTrig = extTrig || intTrig;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_d        = state_q;
    state_d.launch = 1'b0;
    state_d.shadow = 1'b0;
    state_d.rdValid = 1'b0;
    state_d.pinPrev = pinActive;
    state_d.evtPrev = evtNow;

    // launch timer
    case (state_q.tmr)
      TMR_IDLE: begin
        if (anyTrig) begin
          // a delay of zero launches like a delay of one, so the counter never wraps
          if (state_q.launchDly <= CNT_ONE) begin
            state_d.launch = 1'b1;
          end else begin
            state_d.tmr = TMR_COUNT;
            state_d.cnt = state_q.launchDly - CNT_ONE;
          end
        end
      end
      TMR_COUNT: begin
        if (bypass && extTrig) begin
          state_d.launch = 1'b1;
          state_d.tmr    = TMR_IDLE;
        end else if (state_q.cnt == CNT_ONE) begin
          state_d.launch = 1'b1;
          state_d.tmr    = TMR_IDLE;
        end else begin
          state_d.cnt = state_q.cnt - CNT_ONE;
        end
      end
      default: state_d.tmr = TMR_IDLE;
    endcase
    // a bypassed pin trigger wins over any countdown and ends it, so that
    // one trigger never yields a second, late pulse
    if (bypass && extTrig) begin
      state_d.launch = 1'b1;
      state_d.tmr    = TMR_IDLE;
    end

    // shadow set load strobe
    state_d.shadow = state_q.launch && startEn[SHADOW_BIT];

    // start pin output stretch
    if (state_q.launch && pinIsOutput) begin
      state_d.pinOn  = 1'b1;
      state_d.outCnt = state_q.pulseExt;
    end else if (state_q.pinOn) begin
      if (state_q.outCnt == RST_ZERO) begin
        state_d.pinOn = 1'b0;
      end else begin
        state_d.outCnt = state_q.outCnt - CNT_ONE;
      end
    end

    // deferred parameters: transfer on start, then host write
    // the transfer comes first, so a write in the launch cycle stays pending
    for (int i = 0; i < NUM_DEFER; i++) begin
      if (state_q.launch && state_q.pendFlag[i]) begin
        state_d.active[i]   = state_q.pending[i];
        state_d.pendFlag[i] = 1'b0;
      end
      if (regWrEn && regWrAddr == deferAddr[i]) begin
        if (startEn[i]) begin
          state_d.pending[i]  = regWrData;
          state_d.pendFlag[i] = 1'b1;
        end else begin
          state_d.active[i] = regWrData;
        end
      end
    end

    // configuration writes
    if (regWrEn) begin
      if (regWrAddr == ADDR_SYNC_CONFIG) begin
        state_d.cfg = {{(DATA_W-CFG_USED_W){1'b0}}, regWrData[CFG_USED_W-1:0]};
      end else if (regWrAddr == ADDR_PULSE_EXT) begin
        state_d.pulseExt = regWrData;
      end else if (regWrAddr == ADDR_LAUNCH_DLY) begin
        state_d.launchDly = regWrData;
      end
    end

    // pin level follows the polarity held after this edge, so a polarity
    // write never leaves a stale level on the pin
    state_d.pinLevel = state_d.cfg[POL_BIT] ? state_d.pinOn : !state_d.pinOn;

    // register reads, answered one cycle later
    if (regRdEn) begin
      state_d.rdValid = 1'b1;
      if (regRdAddr == ADDR_SYNC_CONFIG) begin
        state_d.rdData = state_q.cfg;
      end else if (regRdAddr == ADDR_PULSE_EXT) begin
        state_d.rdData = state_q.pulseExt;
      end else if (regRdAddr == ADDR_LAUNCH_DLY) begin
        state_d.rdData = state_q.launchDly;
      end else if (regRdAddr == ADDR_TARGET_POS) begin
        state_d.rdData = state_q.active[0];
      end else if (regRdAddr == ADDR_MAX_VEL) begin
        state_d.rdData = state_q.active[1];
      end else if (regRdAddr == ADDR_RAMP_MODE) begin
        state_d.rdData = state_q.active[2];
      end else if (regRdAddr == ADDR_GEAR) begin
        state_d.rdData = state_q.active[3];
      end else if (regRdAddr == ADDR_SYNC_STATUS) begin
        state_d.rdData = {{(DATA_W-NUM_DEFER-2){1'b0}}, state_q.pinOn, state_q.tmr, state_q.pendFlag};
      end else begin
        state_d.rdData = RST_ZERO; // unmapped reads as zero
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q          <= '0;
      state_q.tmr      <= TMR_IDLE;
      state_q.pinLevel <= 1'b1; // idle high for the default low-active pin
    end else begin
      state_q <= state_d;
    end
  end

  // outputs
  assign regRdData       = state_q.rdData;
  assign regRdValid      = state_q.rdValid;
  assign startPinOut     = state_q.pinLevel;
  assign startPinOe      = pinIsOutput;
  assign targetPosition  = state_q.active[0];
  assign maxVelocity     = state_q.active[1];
  assign rampProfileMode = state_q.active[2];
  assign gearFactor      = state_q.active[3];
  assign startPulse      = state_q.launch;
  assign shadowLoad      = state_q.shadow;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_immediate_write: assert property (
    regWrEn && regWrAddr == ADDR_TARGET_POS && !startEn[0] |=> targetPosition == $past(regWrData))
    else $error("immediate write not applied");
  a_deferred_hold: assert property (
    regWrEn && regWrAddr == ADDR_MAX_VEL && startEn[1] && !(startPulse && state_q.pendFlag[1])
      |=> state_q.pendFlag[1] && $stable(maxVelocity))
    else $error("deferred write leaked or not pending");

  // deferred writes hold back until the start pulse, each on its own
  a_target_defer: assert property (
    regWrEn && regWrAddr == ADDR_TARGET_POS && startEn[0] && !(startPulse && state_q.pendFlag[0])
      |=> state_q.pendFlag[0] && $stable(targetPosition))
    else $error("target write not held back");
  a_ramp_defer: assert property (
    regWrEn && regWrAddr == ADDR_RAMP_MODE && startEn[2] && !(startPulse && state_q.pendFlag[2])
      |=> state_q.pendFlag[2] && $stable(rampProfileMode))
    else $error("ramp mode write not held back");
  a_gear_defer: assert property (
    regWrEn && regWrAddr == ADDR_GEAR && startEn[3] && !(startPulse && state_q.pendFlag[3])
      |=> state_q.pendFlag[3] && $stable(gearFactor))
    else $error("gear write not held back");
  a_pend_indep: assert property (
    regWrEn && regWrAddr == ADDR_TARGET_POS && !startPulse
      |=> state_q.pendFlag[NUM_DEFER-1:1] == $past(state_q.pendFlag[NUM_DEFER-1:1]))
    else $error("target write touched other pending flags");
  a_vel_immediate: assert property (
    regWrEn && regWrAddr == ADDR_MAX_VEL && !startEn[1]
      |=> maxVelocity == $past(regWrData))
    else $error("immediate velocity write not applied");
  a_launch_transfer: assert property (
    startPulse && state_q.pendFlag[2] && !(regWrEn && regWrAddr == ADDR_RAMP_MODE && !startEn[2])
      |=> rampProfileMode == $past(state_q.pending[2]))
    else $error("pending value not transferred on start");
  a_shadow_strobe: assert property (
    startPulse |=> shadowLoad == $past(startEn[SHADOW_BIT]))
    else $error("shadow load strobe wrong");
  a_shadow_quiet: assert property (
    !startPulse
      |=> !shadowLoad)
    else $error("shadow load without start");
  a_delay_short: assert property (
    anyTrig && state_q.tmr == TMR_IDLE && state_q.launchDly <= CNT_ONE |=> startPulse)
    else $error("short delay start missing");
  a_delay_end: assert property (
    state_q.tmr == TMR_COUNT && state_q.cnt == CNT_ONE |=> startPulse)
    else $error("countdown end start missing");
  a_delay_quiet: assert property (
    state_q.tmr == TMR_COUNT && state_q.cnt > CNT_ONE && !(bypass && extTrig) |=> !startPulse)
    else $error("start during countdown");
  a_bypass_now: assert property (
    bypass && extTrig |=> startPulse)
    else $error("bypass start not immediate");

  // trigger recognition and countdown
  a_ext_delayed: assert property (
    !bypass && extTrig && state_q.tmr == TMR_IDLE && state_q.launchDly > CNT_ONE
      |=> !startPulse && state_q.tmr == TMR_COUNT)
    else $error("external trigger not delayed");
  a_bypass_cancel: assert property (
    bypass && extTrig
      |=> state_q.tmr == TMR_IDLE)
    else $error("countdown survives bypass start");
  a_level_quiet: assert property (
    state_q.tmr == TMR_IDLE && !anyTrig
      |=> !startPulse)
    else $error("start without a trigger edge");
  a_event_select: assert property (
    trigSel[1] && targetHitEvent && !state_q.evtPrev[0] && state_q.tmr == TMR_IDLE && state_q.launchDly <= CNT_ONE
      |=> startPulse)
    else $error("enabled event did not start");
  a_zero_select: assert property (
    trigSel == '0 && state_q.tmr == TMR_IDLE
      |=> !startPulse)
    else $error("start with all triggers off");
  a_out_single: assert property (
    startPulse && pinIsOutput && state_q.pulseExt == RST_ZERO
      ##1 !startPulse |=> !state_q.pinOn)
    else $error("output pulse longer than one cycle");

  // start pin output stretch
  a_out_load: assert property (
    startPulse && pinIsOutput
      |=> state_q.pinOn && state_q.outCnt == $past(state_q.pulseExt))
    else $error("output stretch not loaded on start");
  a_out_stretch: assert property (
    state_q.pinOn && state_q.outCnt != RST_ZERO && !startPulse
      |=> state_q.pinOn && state_q.outCnt == $past(state_q.outCnt) - CNT_ONE)
    else $error("output stretch ended early");
  a_out_level: assert property (
    startPinOe |-> startPinOut == (polHigh ? state_q.pinOn : !state_q.pinOn))
    else $error("pin level disagrees with polarity");
  a_input_mode: assert property (
    pinIsInput |-> !startPinOe)
    else $error("pin driven while an input");

  // ****************************************
  // cover points
  // ****************************************
  c_deferred_start: cover property (state_q.pendFlag[0] && startPulse);
  c_ext_countdown: cover property (extTrig && !bypass && state_q.tmr == TMR_IDLE);
  c_bypass_preempt: cover property (state_q.tmr == TMR_COUNT && bypass && extTrig);
  c_stretched_out: cover property (state_q.pinOn && state_q.outCnt > CNT_ONE);
  c_event_trigger: cover property (intTrig && state_q.tmr == TMR_IDLE);

endmodule // rss_ramp_start_sync

// ---- verif/rss_pin_partner.sv ----
// start pin partner: another controller sharing the start pin
`timescale 1ns/1ps
module rss_pin_partner (
  // control from the bench
  input  wire logic enable,
  input  wire logic activeHigh,
  input  wire logic fire,
  // pin drive, released when not enabled
  output logic      drvOe,
  output logic      drvLevel
);
  // idle at the inactive level, active level while firing
  assign drvOe    = enable;
  assign drvLevel = fire ? activeHigh : !activeHigh;
endmodule // rss_pin_partner

// ---- verif/tb_top.sv ----
// testbench: register tasks and start synchronizer scenarios
`timescale 1ns/1ps
module tb_top import rss_pkg::*; ;
  logic              core_clk, arst_n, regWrEn, regRdEn, regRdValid, startPinIn, startPinOut, startPinOe;
  logic              startPulse, shadowLoad, pEn, pFire, pAh, pOe, pLvl;
  logic [ADDR_W-1:0] regWrAddr, regRdAddr;
  logic [DATA_W-1:0] regWrData, regRdData;
  logic [DATA_W-1:0] pv [4];
  logic [DATA_W-1:0] act [4];
  logic [DATA_W-1:0] nv [4];
  logic [2:0]        ev;
  int                miscompares, n_compared, npul;

  // shared pin: device drive, partner drive, else pull-up
  assign startPinIn = startPinOe ? startPinOut : (pOe ? pLvl : 1'h1);

  rss_ramp_start_sync dut_u (.core_clk(core_clk), .arst_n(arst_n), .regWrEn(regWrEn), .regWrAddr(regWrAddr),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdAddr(regRdAddr), .regRdData(regRdData),
    .regRdValid(regRdValid), .targetHitEvent(ev[0]), .velocityHitEvent(ev[1]), .positionCompareEvent(ev[2]),
    .startPinIn(startPinIn), .startPinOut(startPinOut), .startPinOe(startPinOe), .targetPosition(pv[0]),
    .maxVelocity(pv[1]), .rampProfileMode(pv[2]), .gearFactor(pv[3]), .startPulse(startPulse),
    .shadowLoad(shadowLoad));
  rss_pin_partner part_u (.enable(pEn), .activeHigh(pAh), .fire(pFire), .drvOe(pOe), .drvLevel(pLvl));

  // clock
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = !core_clk;
  end
  // count start pulses
  always @(posedge core_clk) begin
    if (startPulse === 1'h1) npul++;
  end
  // watchdog
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string nm, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    #1;
    regWrEn   = 1'h1;
    regWrAddr = a;
    regWrData = d;
    @(posedge core_clk);
    #1;
    regWrEn = 1'h0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge core_clk);
    #1;
    regRdEn   = 1'h1;
    regRdAddr = a;
    @(posedge core_clk);
    #1;
    regRdEn = 1'h0;
    chk("regRdValid", 32'h0000_0001, 32'(regRdValid));
    chk("regRdData", exp, regRdData);
  endtask
  function automatic logic [DATA_W-1:0] cfg(input logic [4:0] en, input logic [3:0] trg, input logic pol, byp);
    return {21'h0, byp, pol, trg, en};
  endfunction
  task automatic end_sim;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    int base;
    logic [4:0] m;
    {arst_n, regWrEn, regRdEn, pEn, pFire, pAh, ev} = 9'h000;
    {regWrAddr, regRdAddr, regWrData} = '0;
    act = '{default: '0};
    repeat (16) @(posedge core_clk);
    #1;
    arst_n = 1'h1;
    rd(ADDR_SYNC_CONFIG, RST_ZERO);
    rd(ADDR_PULSE_EXT, RST_ZERO);
    rd(ADDR_LAUNCH_DLY, RST_ZERO);
    rd(7'h7F, RST_ZERO);
    wr(ADDR_SYNC_CONFIG, 32'hFFFF_FFFF);
    rd(ADDR_SYNC_CONFIG, 32'h0000_07FF);
    wr(ADDR_SYNC_CONFIG, RST_ZERO);
    // all-zero select: events start nothing, pin released
    base = npul;
    ev = 3'h7;
    repeat (4) @(posedge core_clk);
    #1;
    ev = 3'h0;
    chk("pulses", 32'(base), 32'(npul));
    chk("startPinOe", 32'h0, 32'(startPinOe));
    // internal events, output pin, deferred parameters
    for (int i = 0; i < 5; i++) begin
      m = (i == 4) ? 5'h1A : 5'(1 << i);
      wr(ADDR_LAUNCH_DLY, 32'(i + 1));
      wr(ADDR_PULSE_EXT, 32'(i));
      rd(ADDR_LAUNCH_DLY, 32'(i + 1));
      wr(ADDR_SYNC_CONFIG, cfg(m, 4'(2 << (i % 3)), i[0], 1'h0));
      for (int k = 0; k < 4; k++) begin
        nv[k] = 32'h00A0_0000 + 32'(i * 16 + k);
        wr(ADDR_TARGET_POS + 7'(k), 32'hDEAD_0000);
        wr(ADDR_TARGET_POS + 7'(k), nv[k]);
        if (!m[k]) act[k] = nv[k];
        chk("param", act[k], pv[k]);
      end
      rd(ADDR_SYNC_STATUS, 32'(m[3:0]));
      chk("startPinOe", 32'h1, 32'(startPinOe));
      chk("startPinOut", 32'(!i[0]), 32'(startPinOut));
      base = npul;
      ev[i % 3] = 1'h1;
      repeat (i + 1) @(posedge core_clk);
      #1;
      chk("startPulse", 32'h1, 32'(startPulse));
      for (int j = 0; j <= i; j++) begin
        @(posedge core_clk);
        #1;
        chk("startPinOut", 32'(i[0]), 32'(startPinOut));
        if (j == 0) chk("shadowLoad", 32'(m[4]), 32'(shadowLoad));
      end
      @(posedge core_clk);
      #1;
      chk("startPinOut", 32'(!i[0]), 32'(startPinOut));
      for (int k = 0; k < 4; k++) begin
        if (m[k]) act[k] = nv[k];
        chk("param", act[k], pv[k]);
      end
      repeat (8) @(posedge core_clk);
      #1;
      ev = 3'h0;
      chk("pulses", 32'(base + 1), 32'(npul));
    end
    // external pin trigger delayed, retrigger while counting ignored
    pEn = 1'h1;
    wr(ADDR_LAUNCH_DLY, 32'h0000_0004);
    wr(ADDR_SYNC_CONFIG, cfg(5'h00, 4'h1, 1'h0, 1'h0));
    chk("startPinOe", 32'h0, 32'(startPinOe));
    base = npul;
    pFire = 1'h1;
    @(posedge core_clk);
    #1;
    pFire = 1'h0;
    @(posedge core_clk);
    #1;
    pFire = 1'h1;
    repeat (2) @(posedge core_clk);
    #1;
    chk("startPulse", 32'h1, 32'(startPulse));
    pFire = 1'h0;
    repeat (8) @(posedge core_clk);
    #1;
    chk("pulses", 32'(base + 1), 32'(npul));
    // bypass: pin trigger pre-empts an event countdown
    wr(ADDR_LAUNCH_DLY, 32'h0000_0006);
    wr(ADDR_SYNC_CONFIG, cfg(5'h00, 4'h9, 1'h0, 1'h1));
    base = npul;
    ev[2] = 1'h1;
    repeat (2) @(posedge core_clk);
    #1;
    pFire = 1'h1;
    @(posedge core_clk);
    #1;
    chk("startPulse", 32'h1, 32'(startPulse));
    pFire = 1'h0;
    ev = 3'h0;
    repeat (10) @(posedge core_clk);
    #1;
    chk("pulses", 32'(base + 1), 32'(npul));
    // active-high pin input: one rising edge gives one pulse, a held level no more
    wr(ADDR_SYNC_CONFIG, RST_ZERO);
    pAh = 1'h1;
    wr(ADDR_LAUNCH_DLY, CNT_ONE);
    wr(ADDR_SYNC_CONFIG, cfg(5'h00, 4'h1, 1'h1, 1'h0));
    chk("startPinOe", 32'h0, 32'(startPinOe));
    @(posedge core_clk);
    #1;
    base = npul;
    pFire = 1'h1;
    @(posedge core_clk);
    #1;
    chk("startPulse", 32'h1, 32'(startPulse));
    repeat (6) @(posedge core_clk);
    #1;
    pFire = 1'h0;
    chk("pulses", 32'(base + 1), 32'(npul));
    end_sim();
  end
endmodule // tb_top
